/* src/acs_sequencer.sv */
// operating-mode sequencer: background calibration and sleep with wake-up
// Functional notes
// - mode code 101 starts background calibration at next conversion period start
// - offset phase: ready high after its first period, inputs shorted, three periods, four first time in slave
// - then input reconnected, three refill periods, ready low on the following period
// - in the valid-data period switch to reference; it and the next two periods are gain calibration
// - then three refill periods, ready low, short input, offset again, loop
// - background mode yields one valid period out of six
// - background calibration persists until another mode code is written
// - code 110 enters sleep; only another mode code leaves it
// - sleep powers down analog and logic; bias and reference keep their own enables
// - chip select low wakes serial communication in sleep
// - in slave with chip select tied low, an instruction byte wakes serial
// - leaving sleep: brief power-up, two conversions, then new mode applies
// - ready stays high through first and second conversion after sleep
// - code 000 is normal conversion
`timescale 1ns/100ps
`include "acs_map.svh"
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int PWRUP_CYC = `ACS_WAKE_PWRUP_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [2:0] operationModeField,
  input wire logic periodStart,
  input wire logic slaveMode,
  input wire logic chipSelectN,
  input wire logic serialDataIn,
  input wire logic instrByteSeen,
  output logic data_ready_n,
  output logic inputShort,
  output logic refSelect,
  output logic powerDown,
  output logic serialAwake
);
  acs_regs_t r;
  acs_regs_t next_r;
  logic sdFall;

  ////////////////////////////////////////////////////////////////////////
  // serial data falling edge after long enough high, for master wake
  assign sdFall = r.sdPrev && !serialDataIn && (r.sdHigh == `ACS_SD_HIGH_CYC);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.powerDown = 1'b0;
    next_r.sdPrev = serialDataIn;
    if (!serialDataIn) begin
      next_r.sdHigh = 3'h0;
    end else if (r.sdHigh != `ACS_SD_HIGH_CYC) begin
      next_r.sdHigh = r.sdHigh + 3'h1;
    end
    case (r.st)
      ACS_NORMAL: begin
        next_r.dataReadyN = 1'b0;
        next_r.inputShort = 1'b0;
        next_r.refSelect = 1'b0;
        next_r.firstOfs = 1'b1;
        if (operationModeField == `ACS_MODE_SLEEP) begin
          next_r.st = ACS_SLEEP;
          next_r.powerDown = 1'b1;
          next_r.serialAwake = 1'b0;
        end else if (operationModeField == `ACS_MODE_BGCAL && periodStart) begin
          next_r.st = ACS_OFS;
          next_r.cnt = 3'h0;
          next_r.dataReadyN = 1'b1;
          next_r.inputShort = 1'b1;
        end
      end
      ACS_OFS: begin
        if (operationModeField != `ACS_MODE_BGCAL) begin
          next_r.st = ACS_NORMAL;
        end else if (periodStart) begin
          next_r.dataReadyN = 1'b1;
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt + 3'h1 == ((slaveMode && r.firstOfs) ? `ACS_OFS_FIRST_SLAVE : `ACS_OFS_PERIODS)) begin
            next_r.st = ACS_FILL1;
            next_r.cnt = 3'h0;
            next_r.firstOfs = 1'b0;
            next_r.inputShort = 1'b0;
          end
        end
      end
      ACS_FILL1: begin
        if (operationModeField != `ACS_MODE_BGCAL) begin
          next_r.st = ACS_NORMAL;
        end else if (periodStart) begin
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt + 3'h1 == `ACS_FILL_PERIODS) begin
            next_r.st = ACS_GAIN;
            next_r.cnt = 3'h0;
            next_r.dataReadyN = 1'b0;
            next_r.refSelect = 1'b1;
          end
        end
      end
      ACS_GAIN: begin
        if (operationModeField != `ACS_MODE_BGCAL) begin
          next_r.st = ACS_NORMAL;
        end else if (periodStart) begin
          next_r.dataReadyN = 1'b1;
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt + 3'h1 == `ACS_GAIN_PERIODS) begin
            next_r.st = ACS_FILL2;
            next_r.cnt = 3'h0;
            next_r.refSelect = 1'b0;
          end
        end
      end
      ACS_FILL2: begin
        if (operationModeField != `ACS_MODE_BGCAL) begin
          next_r.st = ACS_NORMAL;
        end else if (periodStart) begin
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt + 3'h1 == `ACS_FILL_PERIODS) begin
            next_r.st = ACS_OFS;
            next_r.cnt = 3'h0;
            next_r.dataReadyN = 1'b0;
            next_r.inputShort = 1'b1;
          end
        end
      end
      ACS_SLEEP: begin
        next_r.powerDown = 1'b1;
        next_r.dataReadyN = 1'b1;
        if (!chipSelectN || sdFall || (slaveMode && instrByteSeen)) begin
          next_r.serialAwake = 1'b1;
        end
        if (operationModeField != `ACS_MODE_SLEEP) begin
          next_r.st = ACS_PWRUP;
          next_r.wakeMode = operationModeField;
          next_r.pwr = 4'h0;
          next_r.powerDown = 1'b0;
          next_r.serialAwake = 1'b1;
        end
      end
      ACS_PWRUP: begin
        next_r.pwr = r.pwr + 4'h1;
        if (32'(r.pwr) + 1 >= PWRUP_CYC && periodStart) begin
          next_r.st = ACS_WAKE1;
        end
      end
      ACS_WAKE1: begin
        if (periodStart) begin
          next_r.st = ACS_WAKE2;
        end
      end
      ACS_WAKE2: begin
        if (periodStart) begin
          next_r.st = ACS_NORMAL;
          if (r.wakeMode == `ACS_MODE_BGCAL) begin
            next_r.st = ACS_OFS;
            next_r.cnt = 3'h0;
            next_r.inputShort = 1'b1;
          end else begin
            next_r.dataReadyN = 1'b0;
          end
        end
      end
      default: begin
        next_r.st = ACS_NORMAL;
      end
    endcase
    if (r.st == ACS_PWRUP && 32'(r.pwr) + 1 >= PWRUP_CYC && !periodStart) begin
      next_r.pwr = r.pwr;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: ACS_NORMAL, cnt: 3'h0, pwr: 4'h0, firstOfs: 1'b1, wakeMode: 3'h0,
             dataReadyN: 1'b1, inputShort: 1'b0, refSelect: 1'b0, powerDown: 1'b0, serialAwake: 1'b1,
             sdPrev: 1'b0, sdHigh: 3'h0};
    end else begin
      r <= next_r;
    end
  end

  assign data_ready_n = r.dataReadyN;
  assign inputShort = r.inputShort;
  assign refSelect = r.refSelect;
  assign powerDown = r.powerDown;
  assign serialAwake = r.serialAwake;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_ofs_short: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_OFS) |-> inputShort) else $error("offset phase not shorted");
  a_ofs_ready: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_OFS && r.cnt != 3'h0) |-> data_ready_n) else $error("ready low inside offset phase");
  a_gain_ref: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_GAIN && $past(r.st) == ACS_FILL1) |-> (refSelect && !data_ready_n))
    else $error("gain phase not on reference");
  a_sleep_pd: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_SLEEP) |-> powerDown) else $error("sleep not powered down");
  a_sleep_enter: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_NORMAL && operationModeField == `ACS_MODE_SLEEP) |=> (r.st == ACS_SLEEP))
    else $error("sleep not entered");
  a_wake_rdy: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_WAKE1 || r.st == ACS_WAKE2) |-> data_ready_n) else $error("ready low during wake");
  a_bg_exit: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_FILL1 && operationModeField != `ACS_MODE_BGCAL) |=> (r.st == ACS_NORMAL))
    else $error("background not left");
  a_cs_wake: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_SLEEP && !chipSelectN) |=> serialAwake) else $error("chip select did not wake");
  a_fill_in: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_FILL1 || r.st == ACS_FILL2) |-> (!inputShort && !refSelect && data_ready_n))
    else $error("refill with input switched");
  a_bg_enter: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_NORMAL && operationModeField == `ACS_MODE_BGCAL && periodStart)
    |=> (r.st == ACS_OFS && inputShort && data_ready_n)) else $error("background not entered");
  a_pd_only_sleep: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st != ACS_SLEEP) |-> !powerDown) else $error("powered down outside sleep");
  a_sd_wake: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_SLEEP && sdFall) |=> serialAwake) else $error("serial data edge did not wake");
  a_wake_bg: assert property (@(posedge core_clk) disable iff (!rstn)
    (r.st == ACS_WAKE2 && periodStart && r.wakeMode == `ACS_MODE_BGCAL) |=> (r.st == ACS_OFS))
    else $error("wake mode not applied");
endmodule : acs_sequencer

/* src/acs_map.svh */
// offsets-free constant map of the calibration and sleep sequencer
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_MODE_NORMAL 3'h0
`define ACS_MODE_BGCAL 3'h5
`define ACS_MODE_SLEEP 3'h6
`define ACS_OFS_PERIODS 3'h3
`define ACS_OFS_FIRST_SLAVE 3'h4
`define ACS_GAIN_PERIODS 3'h3
`define ACS_FILL_PERIODS 3'h3
`define ACS_RATE_DIV 3'h6
`define ACS_SD_HIGH_CYC 3'h4
`define ACS_WAKE_PWRUP_NS 200
`define ACS_CLK_NS 50
`define ACS_WAKE_PWRUP_CYC ((`ACS_WAKE_PWRUP_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`endif

/* src/acs_pkg.sv */
// types of the calibration and sleep sequencer
package acs_pkg;
  typedef enum logic [8:0] {
    ACS_NORMAL = 9'h001,
    ACS_OFS = 9'h002,
    ACS_FILL1 = 9'h004,
    ACS_GAIN = 9'h008,
    ACS_FILL2 = 9'h010,
    ACS_SLEEP = 9'h020,
    ACS_PWRUP = 9'h040,
    ACS_WAKE1 = 9'h080,
    ACS_WAKE2 = 9'h100
  } acs_state_t;
  typedef struct packed {
    acs_state_t st;
    logic [2:0] cnt;
    logic [3:0] pwr;
    logic firstOfs;
    logic [2:0] wakeMode;
    logic dataReadyN;
    logic inputShort;
    logic refSelect;
    logic powerDown;
    logic serialAwake;
    logic sdPrev;
    logic [2:0] sdHigh;
  } acs_regs_t;
endpackage : acs_pkg

/* sim/acs_host.sv */
// host model: mode writes and serial wake-up
`timescale 1ns/100ps
module acs_host (
  input wire logic core_clk,
  output logic [2:0] mode,
  output logic csN,
  output logic sdi,
  output logic instr
);
  initial begin
    mode = 3'h0;
    csN = 1'b1;
    sdi = 1'b0;
    instr = 1'b0;
  end
  task automatic setMode(input logic [2:0] m);
    @(posedge core_clk) mode <= m;
  endtask : setMode
  task automatic csWake;
    @(posedge core_clk) csN <= 1'b0;
    repeat (3) @(posedge core_clk);
    csN <= 1'b1;
  endtask : csWake
  task automatic sdiWake;
    @(posedge core_clk) sdi <= 1'b1;
    repeat (5) @(posedge core_clk);
    sdi <= 1'b0;
  endtask : sdiWake
  task automatic instrWake;
    @(posedge core_clk) instr <= 1'b1;
    @(posedge core_clk) instr <= 1'b0;
  endtask : instrWake
endmodule : acs_host

/* sim/tb_top.sv */
// self-checking bench of the calibration and sleep sequencer
`timescale 1ns/100ps
module tb_top;
  logic core_clk;
  logic rstn;
  logic periodStart;
  logic slaveMode;
  logic instrByteSeen;
  logic [2:0] mode;
  logic csN;
  logic sdi;
  logic dReadyN;
  logic inShort;
  logic refSel;
  logic pDown;
  logic sAwake;
  logic [4:0] outs;
  int nFail;
  int numChecks;
  // {ready_n, short, ref, power-down, awake} after each boundary of the loop
  logic [4:0] bgSeq [16] = '{5'h19, 5'h19, 5'h19, 5'h11, 5'h11, 5'h11, 5'h05, 5'h15,
                             5'h15, 5'h11, 5'h11, 5'h11, 5'h09, 5'h19, 5'h19, 5'h11};
  acs_sequencer #(.PWRUP_CYC(2)) DUT (.core_clk(core_clk), .rstn(rstn), .operationModeField(mode),
    .periodStart(periodStart), .slaveMode(slaveMode), .chipSelectN(csN), .serialDataIn(sdi),
    .instrByteSeen(instrByteSeen), .data_ready_n(dReadyN), .inputShort(inShort), .refSelect(refSel),
    .powerDown(pDown), .serialAwake(sAwake));
  acs_host host (.core_clk(core_clk), .mode(mode), .csN(csN), .sdi(sdi), .instr(instrByteSeen));
  assign outs = {dReadyN, inShort, refSel, pDown, sAwake};
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (nFail == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic pulse;
    @(posedge core_clk) periodStart <= 1'b1;
    @(posedge core_clk) periodStart <= 1'b0;
    tick(2);
  endtask : pulse
  task automatic doReset;
    @(posedge core_clk) rstn <= 1'b0;
    tick(11);
    check(outs, 5'h11);
    @(posedge core_clk) rstn <= 1'b1;
    tick(1);
    check(outs, 5'h01);
  endtask : doReset
  task automatic bgRun(input int n, input logic sl);
    for (int k = 0; k < n; k++) begin
      pulse();
      check(outs, bgSeq[(sl && k > 0) ? k - 1 : k]);
    end
  endtask : bgRun
  task automatic wakeNormal;
    host.setMode(3'h0);
    tick(4);
    check(outs, 5'h11);
    for (int k = 0; k < 3; k++) begin
      pulse();
      check(outs, (k < 2) ? 5'h11 : 5'h01);
    end
  endtask : wakeNormal
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    nFail++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    periodStart = 1'b0;
    slaveMode = 1'b0;
    nFail = 0;
    numChecks = 0;
    doReset();
    host.setMode(3'h5);
    tick(3);
    check(outs, 5'h01);
    bgRun(16, 1'b0);
    host.setMode(3'h0);
    tick(3);
    check(outs, 5'h01);
    host.setMode(3'h6);
    tick(2);
    check(outs, 5'h12);
    host.csWake();
    tick(0);
    check(outs, 5'h13);
    wakeNormal();
    host.setMode(3'h6);
    tick(2);
    check(outs, 5'h12);
    host.sdiWake();
    tick(2);
    check(outs, 5'h13);
    wakeNormal();
    host.setMode(3'h6);
    tick(2);
    host.setMode(3'h5);
    tick(4);
    check(outs, 5'h11);
    pulse();
    check(outs, 5'h11);
    pulse();
    check(outs, 5'h11);
    bgRun(4, 1'b0);
    host.setMode(3'h0);
    tick(3);
    check(outs, 5'h01);
    @(posedge core_clk) slaveMode <= 1'b1;
    host.setMode(3'h6);
    tick(2);
    check(outs, 5'h12);
    host.instrWake();
    tick(2);
    check(outs, 5'h13);
    wakeNormal();
    doReset();
    host.setMode(3'h5);
    bgRun(14, 1'b1);
    complete_run();
  end
endmodule : tb_top
